/* File: rtl/piod_decoder.sv */
// Decoder for the flag test, internal register, hardware control, port I/O,
// bank, halt and clock stop instruction groups.
// Assumes the core gives each word with instr_valid, and that memory, port
// and internal register read data for the fields of that word arrive in the
// same cycle.
`timescale 1ns/100ps
// Operation
// - 000000_00_1101: skip when masked unlock bits zero
// - Prefix 111110 loads synthesizer register from memory
// - Prefix 001110 copies internal register into memory
// - Prefix 001111 copies memory into internal register
// - 111111_10 writes nibble into port control word
// - Prefix 111010 loads selected port into memory
// - Prefix 111011 drives memory nibble onto port
// - 111111_00/01 port tests skip on ones/zeros
// - Halt loads release nibble, stops CPU clock
module piod_decoder #(
   parameter int NIB = 4
) (
   input wire logic core_clk,                // 250 MHz instruction clock
   input wire logic resetn,                  // Asynchronous reset, active low
   input wire logic [15:0] instr,            // Instruction word
   input wire logic instr_valid,             // Word present this cycle
   input wire logic [NIB-1:0] unlock_ff,     // Unlock flip-flops
   input wire logic [NIB-1:0] mem_rd_data,   // Memory nibble at row/column of instr
   input wire logic [NIB-1:0] intreg_rd_data, // Internal register chosen by low nibble
   input wire logic [NIB-1:0] port_lo_data,  // Port chosen by low nibble
   input wire logic [NIB-1:0] port_hi_data,  // Port chosen by bits 7..4
   input wire logic hold_in,                 // Hold pin level
   input wire logic halt_wake,               // Halt release event
   output logic skip_next,                   // Skip following instruction
   output logic mem_wr_en,                   // Memory write strobe
   output logic [1:0] mem_row,               // Memory row
   output logic [NIB-1:0] mem_col,           // Memory column
   output logic [NIB-1:0] mem_wr_data,       // Memory write data
   output logic synth_load,                  // Synthesizer register load
   output logic [NIB-1:0] synth_sel,         // Synthesizer register chosen
   output logic [NIB-1:0] synth_data,        // Synthesizer load data
   output logic intreg_wr_en,                // Internal register write
   output logic [NIB-1:0] internal_reg_select, // Internal register chosen
   output logic [NIB-1:0] intreg_wr_data,    // Internal register data
   output logic port_wr_en,                  // Port write strobe
   output logic [NIB-1:0] port_select,       // Port chosen for write/bit ops
   output logic [NIB-1:0] port_wr_data,      // Port data or bit mask
   output logic port_bit_set,                // Set masked port bits
   output logic port_bit_clear,              // Clear masked port bits
   output logic port_dir_wr_en,              // Port control word write
   output logic [NIB-1:0] port_word_select,  // Port control word chosen
   output logic [NIB-1:0] port_dir_data,     // Port control word value
   output logic ctrl_wr_en,                  // Hardware control write
   output logic [3:0] ctrl_code,             // Which control register
   output logic [NIB-1:0] ctrl_data,         // Control immediate
   output logic [NIB-1:0] halt_release,      // Halt release conditions
   output logic cpu_clk_stop,                // CPU clock stopped
   output logic oscillator_stop              // Crystal oscillator stopped
);
   // Field slicing serves four-bit nibbles only
   if (NIB != 4) begin : g_nib_check
      $error("piod_decoder: NIB must be 4");
   end

   typedef struct packed {
      logic skip;
      logic mem_we;
      logic [1:0] row;
      logic [NIB-1:0] col;
      logic [NIB-1:0] mem_wd;
      logic syn_ld;
      logic [NIB-1:0] syn_sel;
      logic [NIB-1:0] syn_d;
      logic ir_we;
      logic [NIB-1:0] ir_sel;
      logic [NIB-1:0] ir_d;
      logic p_we;
      logic [NIB-1:0] p_sel;
      logic [NIB-1:0] p_d;
      logic p_set;
      logic p_clr;
      logic dir_we;
      logic [NIB-1:0] dir_sel;
      logic [NIB-1:0] dir_d;
      logic c_we;
      logic [3:0] c_code;
      logic [NIB-1:0] c_d;
      logic [NIB-1:0] halt_rel;
      logic clk_stop;
      logic osc_stop;
   } piod_state_t;

   piod_state_t st_reg;
   piod_state_t st_next;
   logic [1:0] rst_sync_reg;
   logic rst_n_int;

   // Release the reset through two flops so all state leaves reset together
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n_int = rst_sync_reg[1];

   logic [5:0] pfx;
   logic [1:0] sub;
   logic [3:0] code;
   logic [NIB-1:0] imm;
   logic [NIB-1:0] col_f;
   logic upper_zero;
   logic lock_pass;
   logic port_test_pass;
   logic port_want_ones;

   assign pfx = instr[piod_pkg::PFX_HI:piod_pkg::PFX_LO];
   assign sub = instr[piod_pkg::SUB_HI:piod_pkg::SUB_LO];
   assign code = instr[piod_pkg::CODE_HI:piod_pkg::CODE_LO];
   assign col_f = instr[piod_pkg::CODE_HI:piod_pkg::CODE_LO];
   assign imm = instr[piod_pkg::IMM_HI:piod_pkg::IMM_LO];
   assign upper_zero = (instr[piod_pkg::PFX_HI:piod_pkg::UPPER_LO] == 8'h00);
   assign port_want_ones = (sub == piod_pkg::SUB_TRUE_TEST);

   piod_mask_test #(.WIDTH(NIB)) u_lock_test (
      .value(unlock_ff),
      .mask(imm),
      .want_ones(1'b0),
      .pass(lock_pass)
   );

   piod_mask_test #(.WIDTH(NIB)) u_port_test (
      .value(port_hi_data),
      .mask(imm),
      .want_ones(port_want_ones),
      .pass(port_test_pass)
   );

   always_comb begin
      st_next = st_reg;
      // Strobes last one cycle only
      st_next.skip = 1'b0;
      st_next.mem_we = 1'b0;
      st_next.syn_ld = 1'b0;
      st_next.ir_we = 1'b0;
      st_next.p_we = 1'b0;
      st_next.p_set = 1'b0;
      st_next.p_clr = 1'b0;
      st_next.dir_we = 1'b0;
      st_next.c_we = 1'b0;
      // Wake first, so a halt in the same cycle still wins
      if (halt_wake) begin
         st_next.clk_stop = 1'b0;
      end
      // Oscillator runs again once hold rises
      if (hold_in) begin
         st_next.osc_stop = 1'b0;
      end
      if (instr_valid) begin
         case (pfx)
            piod_pkg::PFX_SYNTH_LOAD: begin
               st_next.row = sub;
               st_next.col = col_f;
               st_next.syn_ld = 1'b1;
               st_next.syn_sel = imm;
               st_next.syn_d = mem_rd_data;
            end
            piod_pkg::PFX_INTREG_READ: begin
               st_next.row = sub;
               st_next.col = col_f;
               st_next.mem_we = 1'b1;
               st_next.mem_wd = intreg_rd_data;
            end
            piod_pkg::PFX_INTREG_WRITE: begin
               st_next.row = sub;
               st_next.col = col_f;
               st_next.ir_we = 1'b1;
               st_next.ir_sel = imm;
               st_next.ir_d = mem_rd_data;
            end
            piod_pkg::PFX_PORT_READ: begin
               st_next.row = sub;
               st_next.col = col_f;
               st_next.mem_we = 1'b1;
               st_next.mem_wd = port_lo_data;
            end
            piod_pkg::PFX_PORT_WRITE: begin
               st_next.row = sub;
               st_next.col = col_f;
               st_next.p_we = 1'b1;
               st_next.p_sel = imm;
               st_next.p_d = mem_rd_data;
            end
            piod_pkg::PFX_ALL_ONES: begin
               case (sub)
                  piod_pkg::SUB_TRUE_TEST,
                  piod_pkg::SUB_FALSE_TEST: begin
                     st_next.skip = port_test_pass;
                  end
                  piod_pkg::SUB_DIR_SET: begin
                     st_next.dir_we = 1'b1;
                     st_next.dir_sel = code;
                     st_next.dir_d = imm;
                  end
                  // Status register and return words belong to other groups
                  default: begin
                  end
               endcase
            end
            piod_pkg::PFX_ALL_ZERO: begin
               case (sub)
                  piod_pkg::SUB_CONTROL: begin
                     case (code)
                        piod_pkg::CODE_LOCK_TEST: begin
                           st_next.skip = lock_pass;
                        end
                        piod_pkg::CODE_HALT: begin
                           st_next.halt_rel = imm;
                           st_next.clk_stop = 1'b1;
                        end
                        piod_pkg::CODE_OSC_STOP: begin
                           if (!hold_in) begin
                              st_next.osc_stop = 1'b1;
                           end
                        end
                        piod_pkg::CODE_COUNTER_ONE,
                        piod_pkg::CODE_COUNTER_TWO,
                        piod_pkg::CODE_BEEP,
                        piod_pkg::CODE_BANK,
                        piod_pkg::CODE_DEAD_BAND,
                        piod_pkg::CODE_TIMER: begin
                           st_next.c_we = upper_zero;
                           st_next.c_code = code;
                           st_next.c_d = imm;
                        end
                        // No operation and words of other groups change nothing
                        default: begin
                        end
                     endcase
                  end
                  piod_pkg::SUB_BIT_SET: begin
                     st_next.p_set = 1'b1;
                     st_next.p_sel = code;
                     st_next.p_d = imm;
                  end
                  piod_pkg::SUB_BIT_CLEAR: begin
                     st_next.p_clr = 1'b1;
                     st_next.p_sel = code;
                     st_next.p_d = imm;
                  end
                  // Serial link control is handled elsewhere
                  default: begin
                  end
               endcase
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign skip_next = st_reg.skip;
   assign mem_wr_en = st_reg.mem_we;
   assign mem_row = st_reg.row;
   assign mem_col = st_reg.col;
   assign mem_wr_data = st_reg.mem_wd;
   assign synth_load = st_reg.syn_ld;
   assign synth_sel = st_reg.syn_sel;
   assign synth_data = st_reg.syn_d;
   assign intreg_wr_en = st_reg.ir_we;
   assign internal_reg_select = st_reg.ir_sel;
   assign intreg_wr_data = st_reg.ir_d;
   assign port_wr_en = st_reg.p_we;
   assign port_select = st_reg.p_sel;
   assign port_wr_data = st_reg.p_d;
   assign port_bit_set = st_reg.p_set;
   assign port_bit_clear = st_reg.p_clr;
   assign port_dir_wr_en = st_reg.dir_we;
   assign port_word_select = st_reg.dir_sel;
   assign port_dir_data = st_reg.dir_d;
   assign ctrl_wr_en = st_reg.c_we;
   assign ctrl_code = st_reg.c_code;
   assign ctrl_data = st_reg.c_d;
   assign halt_release = st_reg.halt_rel;
   assign cpu_clk_stop = st_reg.clk_stop;
   assign oscillator_stop = st_reg.osc_stop;
endmodule // piod_decoder

/* File: rtl/piod_pkg.sv */
// Constants shared by the peripheral I/O instruction decoder.
// Assumes 16-bit instruction words and 4-bit data memory nibbles.
package piod_pkg;
   // Field bounds inside the instruction word
   localparam int WORD_W = 16;
   localparam int NIB_W = 4;
   localparam int PFX_HI = 15;
   localparam int PFX_LO = 10;
   localparam int UPPER_LO = 8;
   localparam int SUB_HI = 9;
   localparam int SUB_LO = 8;
   localparam int CODE_HI = 7;
   localparam int CODE_LO = 4;
   localparam int IMM_HI = 3;
   localparam int IMM_LO = 0;

   // Six-bit prefixes in bits 15..10
   localparam logic [5:0] PFX_SYNTH_LOAD = 6'h3e;
   localparam logic [5:0] PFX_INTREG_READ = 6'h0e;
   localparam logic [5:0] PFX_INTREG_WRITE = 6'h0f;
   localparam logic [5:0] PFX_PORT_READ = 6'h3a;
   localparam logic [5:0] PFX_PORT_WRITE = 6'h3b;
   localparam logic [5:0] PFX_ALL_ONES = 6'h3f;
   localparam logic [5:0] PFX_ALL_ZERO = 6'h00;

   // Sub-codes in bits 9..8
   localparam logic [1:0] SUB_TRUE_TEST = 2'h0;
   localparam logic [1:0] SUB_FALSE_TEST = 2'h1;
   localparam logic [1:0] SUB_DIR_SET = 2'h2;
   localparam logic [1:0] SUB_BIT_SET = 2'h2;
   localparam logic [1:0] SUB_BIT_CLEAR = 2'h3;
   localparam logic [1:0] SUB_CONTROL = 2'h0;

   // Codes in bits 7..4 of the all-zero group with bits 9..8 zero
   localparam logic [3:0] CODE_NOP = 4'h0;
   localparam logic [3:0] CODE_COUNTER_ONE = 4'h1;
   localparam logic [3:0] CODE_COUNTER_TWO = 4'h2;
   localparam logic [3:0] CODE_HALT = 4'h4;
   localparam logic [3:0] CODE_OSC_STOP = 4'h5;
   localparam logic [3:0] CODE_BEEP = 4'h6;
   localparam logic [3:0] CODE_BANK = 4'h7;
   localparam logic [3:0] CODE_DEAD_BAND = 4'hb;
   localparam logic [3:0] CODE_TIMER = 4'hc;
   localparam logic [3:0] CODE_LOCK_TEST = 4'hd;

   localparam logic [3:0] NIB_ZERO = 4'h0;
   localparam logic [1:0] ROW_ZERO = 2'h0;
endpackage

/* File: rtl/piod_mask_test.sv */
// Masked nibble test: all selected bits one, or all selected bits zero.
// Assumes value and mask are stable in the cycle the result is used.
`timescale 1ns/100ps
module piod_mask_test #(
   parameter int WIDTH = 4
) (
   input wire logic [WIDTH-1:0] value,  // Nibble under test
   input wire logic [WIDTH-1:0] mask,   // Bits taking part
   input wire logic want_ones,          // High: test for ones
   output logic pass                    // Condition holds
);
   if (WIDTH < 1) begin : g_width_check
      $error("piod_mask_test: WIDTH must be at least 1");
   end

   always_comb begin
      if (want_ones) begin
         pass = ((value & mask) == mask);
      end else begin
         pass = ((value & mask) == {WIDTH{1'b0}});
      end
   end
endmodule // piod_mask_test

/* File: verification/piod_decoder_assertions.sv */
// Checker for the decoder's strobes and levels against the word taken.
// Assumes binding to piod_decoder; every answer lands one edge after the word, or after the hold level for a_osc_hold.
`timescale 1ns/100ps
module piod_decoder_checker (
   input wire logic core_clk,             // Clock
   input wire logic resetn,               // Reset, active low
   input wire logic [15:0] instr,         // Word
   input wire logic instr_valid,          // Word present
   input wire logic [3:0] unlock_ff,      // Unlock bits
   input wire logic [3:0] mem_rd_data,    // Memory nibble
   input wire logic hold_in,              // Hold level
   input wire logic skip_next,            // Skip strobe
   input wire logic synth_load,           // Synth load
   input wire logic [3:0] synth_sel,      // Synth select
   input wire logic [3:0] synth_data,     // Synth data
   input wire logic intreg_wr_en,         // Intreg write
   input wire logic [3:0] intreg_wr_data, // Intreg data
   input wire logic port_wr_en,           // Port write
   input wire logic [3:0] port_wr_data,   // Port data
   input wire logic port_dir_wr_en,       // Control word write
   input wire logic [3:0] port_dir_data,  // Control word data
   input wire logic cpu_clk_stop,         // CPU clock stopped
   input wire logic [3:0] halt_release,   // Release nibble
   input wire logic oscillator_stop       // Oscillator stopped
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   sequence s_halt_word;
      instr_valid && instr[15:4] == 12'h004;
   endsequence
   a_lock_skip: assert property (
      instr_valid && instr[15:4] == 12'h00d |=> skip_next == (($past(unlock_ff) & $past(instr[3:0])) == 4'h0))
      else $error("lock test skip wrong");
   a_synth_load: assert property (
      instr_valid && instr[15:10] == 6'h3e |=> synth_load && synth_sel == $past(instr[3:0])
      && synth_data == $past(mem_rd_data)) else $error("synth load wrong");
   a_intreg_write: assert property (
      instr_valid && instr[15:10] == 6'h0f |=> intreg_wr_en && intreg_wr_data == $past(mem_rd_data))
      else $error("internal write wrong");
   a_dir_set: assert property (
      instr_valid && instr[15:8] == 8'hfe |=> port_dir_wr_en && port_dir_data == $past(instr[3:0]))
      else $error("direction write wrong");
   a_port_write: assert property (
      instr_valid && instr[15:10] == 6'h3b |=> port_wr_en && port_wr_data == $past(mem_rd_data))
      else $error("port write wrong");
   a_halt_stop: assert property (
      s_halt_word |=> cpu_clk_stop && halt_release == $past(instr[3:0])) else $error("halt wrong");
   a_osc_stop: assert property (
      instr_valid && instr == 16'h0050 && !hold_in |=> oscillator_stop) else $error("osc stop missing");
   a_osc_hold: assert property (
      hold_in |=> !oscillator_stop) else $error("osc stop under hold");
   a_nop_quiet: assert property (
      instr_valid && instr == 16'h0000 |=> !(skip_next || synth_load || port_wr_en || intreg_wr_en
      || port_dir_wr_en)) else $error("nop had effect");
endmodule // piod_decoder_checker
bind piod_decoder piod_decoder_checker i_piod_decoder_checker (.core_clk(core_clk), .resetn(resetn),
   .instr(instr), .instr_valid(instr_valid), .unlock_ff(unlock_ff), .mem_rd_data(mem_rd_data),
   .hold_in(hold_in), .skip_next(skip_next), .synth_load(synth_load), .synth_sel(synth_sel),
   .synth_data(synth_data), .intreg_wr_en(intreg_wr_en), .intreg_wr_data(intreg_wr_data),
   .port_wr_en(port_wr_en), .port_wr_data(port_wr_data), .port_dir_wr_en(port_dir_wr_en),
   .port_dir_data(port_dir_data), .cpu_clk_stop(cpu_clk_stop), .halt_release(halt_release),
   .oscillator_stop(oscillator_stop));

/* File: verification/piod_decoder_bench.sv */
// Self-checking bench for the peripheral I/O instruction decoder.
// Assumes read data inputs answer the fields of the word in its own cycle.
`timescale 1ns/100ps
module piod_decoder_bench;
   logic core_clk, resetn, instr_valid, hold_in, halt_wake;
   logic [15:0] instr;
   logic [3:0] unlock_ff, mem_rd_data, intreg_rd_data, port_lo_data, port_hi_data;
   logic skip_next, mem_wr_en, synth_load, intreg_wr_en, port_wr_en, port_bit_set, port_bit_clear;
   logic port_dir_wr_en, ctrl_wr_en, cpu_clk_stop, oscillator_stop;
   logic [1:0] mem_row;
   logic [3:0] mem_col, mem_wr_data, synth_sel, synth_data, internal_reg_select, intreg_wr_data;
   logic [3:0] port_select, port_wr_data, port_word_select, port_dir_data, ctrl_code, ctrl_data, halt_release;
   int errors, compares;
   piod_decoder i_piod_decoder (.core_clk(core_clk), .resetn(resetn), .instr(instr),
      .instr_valid(instr_valid), .unlock_ff(unlock_ff), .mem_rd_data(mem_rd_data),
      .intreg_rd_data(intreg_rd_data), .port_lo_data(port_lo_data), .port_hi_data(port_hi_data),
      .hold_in(hold_in), .halt_wake(halt_wake), .skip_next(skip_next), .mem_wr_en(mem_wr_en),
      .mem_row(mem_row), .mem_col(mem_col), .mem_wr_data(mem_wr_data), .synth_load(synth_load),
      .synth_sel(synth_sel), .synth_data(synth_data), .intreg_wr_en(intreg_wr_en),
      .internal_reg_select(internal_reg_select), .intreg_wr_data(intreg_wr_data),
      .port_wr_en(port_wr_en), .port_select(port_select), .port_wr_data(port_wr_data),
      .port_bit_set(port_bit_set), .port_bit_clear(port_bit_clear), .port_dir_wr_en(port_dir_wr_en),
      .port_word_select(port_word_select), .port_dir_data(port_dir_data), .ctrl_wr_en(ctrl_wr_en),
      .ctrl_code(ctrl_code), .ctrl_data(ctrl_data), .halt_release(halt_release),
      .cpu_clk_stop(cpu_clk_stop), .oscillator_stop(oscillator_stop));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Idle edge first: valid never falls and rises in one time step; answer read at the next falling edge
   task automatic op(input logic [15:0] w);
      @(negedge core_clk);
      instr = w;
      instr_valid = 1'b1;
      @(negedge core_clk);
      instr_valid = 1'b0;
   endtask
   task automatic conclude();
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic t_lock();
      unlock_ff = 4'h4;
      op(16'h00d3);
      chk(skip_next, 1'b1);
      op(16'h00d4);
      chk(skip_next, 1'b0);
      $display("lock test done");
   endtask
   task automatic t_transfer();
      mem_rd_data = 4'h7;
      op(16'hfa25);
      chk(synth_load, 1'b1);
      chk({synth_sel, synth_data, mem_col, 2'h0, mem_row}, 16'h5722);
      intreg_rd_data = 4'ha;
      op(16'h3a36);
      chk({mem_wr_en, mem_wr_data, mem_col, 2'h0, mem_row}, 16'h1a32);
      mem_rd_data = 4'hc;
      op(16'h3d59);
      chk({intreg_wr_en, internal_reg_select, intreg_wr_data}, 16'h19c);
      $display("transfer test done");
   endtask
   task automatic t_port();
      op(16'hfe7a);
      chk({port_dir_wr_en, port_word_select, port_dir_data}, 16'h17a);
      port_lo_data = 4'h6;
      op(16'he9c4);
      chk({mem_wr_en, mem_wr_data, mem_col, 2'h0, mem_row}, 16'h16c1);
      mem_rd_data = 4'h5;
      op(16'hee83);
      chk({port_wr_en, port_select, port_wr_data}, 16'h135);
      op(16'h0253);
      chk({port_bit_set, port_bit_clear, port_select, port_wr_data}, 16'h253);
      op(16'h0353);
      chk({port_bit_set, port_bit_clear, port_select, port_wr_data}, 16'h153);
      $display("port test done");
   endtask
   task automatic t_port_test();
      logic [15:0] w [4];
      w = '{16'hfc53, 16'hfc57, 16'hfd5c, 16'hfd53};
      port_hi_data = 4'h3;
      for (int i = 0; i < 4; i++) begin
         op(w[i]);
         chk(skip_next, (i % 2) == 0);
      end
      $display("port bit test done");
   endtask
   task automatic t_control();
      logic [3:0] codes [6];
      codes = '{4'h1, 4'h2, 4'h6, 4'hb, 4'hc, 4'h7};
      foreach (codes[i]) begin
         op({8'h00, codes[i], 4'h9 ^ codes[i]});
         chk({ctrl_wr_en, ctrl_code, ctrl_data}, {7'h01, codes[i], 4'h9 ^ codes[i]});
      end
      op(16'h0000);
      chk({skip_next, ctrl_wr_en, mem_wr_en, port_wr_en}, 4'h0);
      op(16'h01a5);
      chk({skip_next, ctrl_wr_en, mem_wr_en, port_wr_en, port_bit_set, port_bit_clear}, 6'h00);
      $display("control test done");
   endtask
   task automatic t_halt();
      op(16'h0049);
      chk({cpu_clk_stop, halt_release}, 5'h19);
      @(negedge core_clk);
      chk(cpu_clk_stop, 1'b1);
      halt_wake = 1'b1;
      @(negedge core_clk);
      halt_wake = 1'b0;
      chk(cpu_clk_stop, 1'b0);
      $display("halt test done");
   endtask
   task automatic t_osc();
      op(16'h0050);
      chk(oscillator_stop, 1'b0);
      hold_in = 1'b0;
      op(16'h0050);
      chk(oscillator_stop, 1'b1);
      hold_in = 1'b1;
      @(negedge core_clk);
      chk(oscillator_stop, 1'b0);
      $display("oscillator test done");
   endtask
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   initial begin
      resetn = 1'b0;
      instr_valid = 1'b0;
      instr = 16'h0000;
      {unlock_ff, mem_rd_data, intreg_rd_data, port_lo_data, port_hi_data} = 20'h00000;
      hold_in = 1'b1;
      halt_wake = 1'b0;
      errors = 0;
      compares = 0;
      repeat (10) @(negedge core_clk);
      resetn = 1'b1;
      // Two synchroniser edges plus one before the first word counts
      repeat (3) @(negedge core_clk);
      t_lock();
      t_transfer();
      t_port();
      t_port_test();
      t_control();
      t_halt();
      t_osc();
      conclude();
   end
endmodule // piod_decoder_bench
